// ==== verilog/pic_pkg.sv ====
package pic_pkg;

   localparam int PIC_DW = 16;
   localparam int PIC_AW = 2;

   // Register indices on the plain register port
   localparam logic [PIC_AW-1:0] PIC_ADDR_CTRL = 2'h0;
   localparam logic [PIC_AW-1:0] PIC_ADDR_MUTE = 2'h1;
   localparam logic [PIC_AW-1:0] PIC_ADDR_TMO = 2'h2;
   localparam logic [PIC_AW-1:0] PIC_ADDR_STAT = 2'h3;

   // Control register field positions
   localparam int PIC_B_POL = 0;
   localparam int PIC_B_START = 2;
   localparam int PIC_B_LONG = 3;
   localparam int PIC_B_REARM = 4;
   localparam int PIC_B_UPS = 5;
   localparam int PIC_B_NINT = 6;

   // Status register field positions
   localparam int PIC_S_STATE = 0;
   localparam int PIC_S_PERMIT = 2;
   localparam int PIC_S_UNPL = 3;
   localparam int PIC_S_TMO = 4;
   localparam int PIC_S_CNT = 5;

   // Reset values: policy all stops, rearm and rising stroke wired, one intervention
   localparam logic [PIC_DW-1:0] PIC_CTRL_RST = 16'h0071;
   localparam logic [PIC_DW-1:0] PIC_MUTE_RST = 16'h0000;
   localparam logic [PIC_DW-1:0] PIC_TMO_RST = 16'h7530;

   // Times in milliseconds, as figures
   localparam logic [PIC_DW-1:0] PIC_PULSE_SHORT_MS = 16'h0064;
   localparam logic [PIC_DW-1:0] PIC_PULSE_LONG_MS = 16'h015e;
   localparam logic [PIC_DW-1:0] PIC_PULSE_MAX_MS = 16'h7530;
   localparam logic [PIC_DW-1:0] PIC_MS_SAT = 16'hffff;

   // Logic cycle and millisecond tick
   localparam int PIC_CLK_NS = 100;
   localparam int PIC_MS_NS = 1000000;
   localparam int PIC_TICK_CYC = (PIC_MS_NS + PIC_CLK_NS - 1) / PIC_CLK_NS;

   typedef enum logic [1:0] {
      PIC_POL_NONE = 2'b00,
      PIC_POL_ALL = 2'b01,
      PIC_POL_DOWN = 2'b10
   } pic_pol_t;

   typedef enum logic [1:0] {
      PIC_ST_STOP = 2'b00,
      PIC_ST_REARM = 2'b01,
      PIC_ST_INTR = 2'b10,
      PIC_ST_RUN = 2'b11
   } pic_state_t;

endpackage

// ==== verilog/pic_tick_if.sv ====
`timescale 1ns/1ps
interface pic_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface

// ==== verilog/pic_tick.sv ====
`timescale 1ns/1ps
module pic_tick import pic_pkg::*; #(
   parameter int TICK_CYCLES = PIC_TICK_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   pic_tick_if.src tk
);
   logic [23:0] cnt;
   wire wrap = (cnt == 24'(TICK_CYCLES - 1));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= 24'h000000;
         tk.tick <= 1'b0;
      end else begin
         cnt <= wrap ? 24'h000000 : cnt + 24'h000001;
         tk.tick <= wrap;
      end
   end
endmodule // pic_tick

// ==== verilog/pic_press_intrusion_cycle_ctrl.sv ====
`timescale 1ns/1ps
module pic_press_intrusion_cycle_ctrl import pic_pkg::*; #(
   parameter int TICK_CYCLES = PIC_TICK_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic static_permit,
   input wire logic start_permit,
   input wire logic presence_sensor_in,
   input wire logic top_dead_centre_position,
   input wire logic rising_stroke,
   input wire logic rearm_in,
   input wire logic drive_active_fb,
   input wire logic [PIC_AW-1:0] reg_addr,
   input wire logic [PIC_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [PIC_DW-1:0] reg_rdata,
   output logic motion_permit,
   output logic rearm_needed,
   output logic intrusion_expected,
   output logic unplanned_intrusion,
   output logic intrusion_timeout,
   output logic fault_flag
);
   pic_tick_if tk ();

   pic_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .clk(clk),
      .sys_rst(sys_rst),
      .tk(tk)
   );

   logic [PIC_DW-1:0] ctrl;
   logic [PIC_DW-1:0] mute_limit;
   logic [PIC_DW-1:0] tmo_limit;
   pic_state_t state;
   pic_state_t next_state;
   logic next_unpl;
   logic next_tmo;
   logic next_quick;
   logic next_permit;
   logic quick_ok;
   logic sens_q;
   logic tdc_q;
   logic ups_q;
   logic rearm_q;
   logic eff_q;
   logic [PIC_DW-1:0] rearm_ms;
   logic [PIC_DW-1:0] gap_ms;
   logic [PIC_DW-1:0] mute_ms;
   logic [PIC_DW-1:0] tmo_ms;
   logic [1:0] intr_cnt;

   // Configuration fields
   wire pic_pol_t pol = pic_pol_t'(ctrl[PIC_B_POL +: 2]);
   wire start_used = ctrl[PIC_B_START];
   wire long_min = ctrl[PIC_B_LONG];
   wire rearm_used = ctrl[PIC_B_REARM];
   wire ups_used = ctrl[PIC_B_UPS];
   wire [1:0] nint_raw = ctrl[PIC_B_NINT +: 2];
   wire [1:0] nint = (nint_raw == 2'h0) ? 2'h1 : nint_raw;
   wire [PIC_DW-1:0] min_ms = long_min ? PIC_PULSE_LONG_MS : PIC_PULSE_SHORT_MS;

   // Edges of the sampled inputs, and the upstroke level
   wire sens_rise = ~sens_q & presence_sensor_in;
   wire tdc_rise = ~tdc_q & top_dead_centre_position;
   wire ups_rise = ~ups_q & rising_stroke;
   wire rearm_rise = ~rearm_q & rearm_in;
   wire rearm_fall = rearm_q & ~rearm_in;
   wire upstroke = ups_used & rising_stroke & ~top_dead_centre_position;

   // muting only exists with rearm and rising stroke wired
   wire mute_en = (mute_limit != 16'h0000) & ups_used & rearm_used;
   // sensor bypass while rising and not yet at top
   wire muting = mute_en & upstroke & (mute_ms < mute_limit);
   // downstroke-only policy holds through the upstroke
   wire down_hold = (pol == PIC_POL_DOWN) & upstroke;
   // after muting expiry the permit tracks the sensor
   wire follow = mute_en & upstroke & ~muting & ~down_hold;
   wire sens_eff = presence_sensor_in | muting | down_hold;
   wire eff_fall = eff_q & ~sens_eff;

   // 0-1-0 pulse between minimum and 30 s
   wire rearm_valid = rearm_used & rearm_fall & (rearm_ms >= min_ms) & (rearm_ms <= PIC_PULSE_MAX_MS);
   wire intr_valid = sens_rise & (gap_ms >= min_ms);
   // policy none or unwired rearm skips the pulse
   wire need_rearm = rearm_used & (pol != PIC_POL_NONE);
   wire quick_pol = (pol == PIC_POL_NONE) | ((pol == PIC_POL_DOWN) & upstroke);
   // start permit checked only when wired
   wire start_ok = ~start_used | start_permit;
   wire tmo_hit = (tmo_limit != 16'h0000) & (tmo_ms >= tmo_limit);
   wire [PIC_DW-1:0] stat_word = {8'h00, 1'b0, intr_cnt, intrusion_timeout, unplanned_intrusion,
                                  motion_permit, state};
   wire [PIC_DW-1:0] rd_mux = (reg_addr == PIC_ADDR_CTRL) ? ctrl :
                              (reg_addr == PIC_ADDR_MUTE) ? mute_limit :
                              (reg_addr == PIC_ADDR_TMO) ? tmo_limit : stat_word;

   // Register port
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= PIC_CTRL_RST;
         mute_limit <= PIC_MUTE_RST;
         tmo_limit <= PIC_TMO_RST;
         reg_rdata <= 16'h0000;
      end else begin
         if (reg_wr && reg_addr == PIC_ADDR_CTRL) begin
            ctrl <= reg_wdata;
         end
         if (reg_wr && reg_addr == PIC_ADDR_MUTE) begin
            mute_limit <= reg_wdata;
         end
         if (reg_wr && reg_addr == PIC_ADDR_TMO) begin
            tmo_limit <= reg_wdata;
         end
         reg_rdata <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sens_q <= 1'b1;
         tdc_q <= 1'b1;
         ups_q <= 1'b0;
         rearm_q <= 1'b0;
         eff_q <= 1'b0;
      end else begin
         sens_q <= presence_sensor_in;
         tdc_q <= top_dead_centre_position;
         ups_q <= rising_stroke;
         rearm_q <= rearm_in;
         eff_q <= sens_eff;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rearm_ms <= 16'h0000;
         gap_ms <= 16'h0000;
         mute_ms <= 16'h0000;
      end else begin
         if (rearm_rise) begin
            rearm_ms <= 16'h0000;
         end else if (rearm_in && tk.tick && rearm_ms != PIC_MS_SAT) begin
            rearm_ms <= rearm_ms + 16'h0001;
         end
         if (sens_q && !presence_sensor_in) begin
            gap_ms <= 16'h0000;
         end else if (!presence_sensor_in && tk.tick && gap_ms != PIC_MS_SAT) begin
            gap_ms <= gap_ms + 16'h0001;
         end
         if (ups_rise) begin
            mute_ms <= 16'h0000;
         end else if (upstroke && tk.tick && mute_ms != PIC_MS_SAT) begin
            mute_ms <= mute_ms + 16'h0001;
         end
      end
   end

   // timer runs only while the fed-back drive command is off
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tmo_ms <= 16'h0000;
      end else if (state != PIC_ST_INTR || drive_active_fb) begin
         tmo_ms <= 16'h0000;
      end else if (tk.tick && tmo_ms != PIC_MS_SAT) begin
         tmo_ms <= tmo_ms + 16'h0001;
      end
   end

   // count cleared at top dead centre edge
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         intr_cnt <= 2'h0;
      end else if (tdc_rise || state != PIC_ST_INTR) begin
         intr_cnt <= 2'h0;
      end else if (intr_valid && intr_cnt != 2'h3) begin
         intr_cnt <= intr_cnt + 2'h1;
      end
   end

   always_comb begin
      next_state = state;
      next_unpl = unplanned_intrusion;
      next_tmo = intrusion_timeout;
      next_quick = quick_ok;
      case (state)
         PIC_ST_STOP: begin
            if (static_permit) begin
               next_state = (need_rearm || unplanned_intrusion || intrusion_timeout) ? PIC_ST_REARM : PIC_ST_INTR;
            end
         end
         PIC_ST_REARM: begin
            if (!static_permit) begin
               next_state = PIC_ST_STOP;
               next_quick = 1'b0;
            end else begin
               if (unplanned_intrusion && !presence_sensor_in && !motion_permit && quick_pol) begin
                  next_quick = 1'b1;
               end
               if (quick_ok && sens_rise && !intrusion_timeout) begin
                  next_unpl = 1'b0;
                  next_quick = 1'b0;
                  next_state = PIC_ST_INTR;
               // valid rearm with sensor high clears errors
               end else if (rearm_valid && presence_sensor_in) begin
                  next_unpl = 1'b0;
                  next_tmo = 1'b0;
                  next_quick = 1'b0;
                  next_state = PIC_ST_INTR;
               // nothing to wait for without errors
               end else if (!need_rearm && !unplanned_intrusion && !intrusion_timeout) begin
                  next_state = PIC_ST_INTR;
               end
            end
         end
         PIC_ST_INTR: begin
            if (!static_permit) begin
               next_state = PIC_ST_STOP;
            end else if (tmo_hit) begin
               next_tmo = 1'b1;
               next_state = PIC_ST_REARM;
            // enough interruptions and start permit present
            end else if (intr_cnt >= nint && presence_sensor_in && start_ok) begin
               next_state = PIC_ST_RUN;
            end
         end
         PIC_ST_RUN: begin
            if (!static_permit) begin
               next_state = PIC_ST_STOP;
            end else if (eff_fall && !follow) begin
               next_unpl = 1'b1;
               next_state = PIC_ST_REARM;
            // end of cycle at top dead centre
            end else if (tdc_rise) begin
               next_state = (pol == PIC_POL_ALL && mute_en) ? PIC_ST_REARM : PIC_ST_INTR;
            end
         end
         default: begin
            next_state = PIC_ST_STOP;
         end
      endcase
   end

   // permit only in run, without errors
   assign next_permit = static_permit & ~next_unpl & ~next_tmo & (next_state == PIC_ST_RUN) &
                        (~follow | presence_sensor_in);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= PIC_ST_STOP;
         quick_ok <= 1'b0;
         motion_permit <= 1'b0;
         rearm_needed <= 1'b0;
         intrusion_expected <= 1'b0;
         unplanned_intrusion <= 1'b0;
         intrusion_timeout <= 1'b0;
         fault_flag <= 1'b0;
      end else begin
         state <= next_state;
         quick_ok <= next_quick;
         motion_permit <= next_permit;
         rearm_needed <= (next_state == PIC_ST_REARM);
         intrusion_expected <= (next_state == PIC_ST_INTR);
         unplanned_intrusion <= next_unpl;
         intrusion_timeout <= next_tmo;
         fault_flag <= next_unpl | next_tmo;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_static_drop;
      !static_permit |=> !motion_permit;
   endproperty
   a_static_drop: assert property (p_static_drop) else $error("permit high after static loss");
   property p_start_gate;
      ($rose(motion_permit) && start_used && $past(state) != PIC_ST_RUN) |-> $past(start_permit);
   endproperty
   a_start_gate: assert property (p_start_gate) else $error("permit rose without start permit");
   property p_mute_hold;
      (state == PIC_ST_RUN && muting && static_permit && !tdc_rise) |=> motion_permit;
   endproperty
   a_mute_hold: assert property (p_mute_hold) else $error("permit lost while muted");
   property p_rearm_exit;
      ($past(state) == PIC_ST_REARM && state == PIC_ST_INTR && $past(need_rearm) && !$past(quick_ok))
      |-> $past(rearm_valid);
   endproperty
   a_rearm_exit: assert property (p_rearm_exit) else $error("left rearm without valid pulse");
   property p_no_mute_stop;
      (state == PIC_ST_RUN && pol == PIC_POL_ALL && !mute_en && static_permit && eff_q && !presence_sensor_in)
      |=> !motion_permit ##0 unplanned_intrusion;
   endproperty
   a_no_mute_stop: assert property (p_no_mute_stop) else $error("sensor drop did not stop");
   property p_rearm_out;
      rearm_needed == (state == PIC_ST_REARM);
   endproperty
   a_rearm_out: assert property (p_rearm_out) else $error("rearm needed mismatch");
   property p_expect_out;
      intrusion_expected == (state == PIC_ST_INTR);
   endproperty
   a_expect_out: assert property (p_expect_out) else $error("intrusion expected mismatch");
   property p_unpl_set;
      (state == PIC_ST_RUN && static_permit && eff_fall && !follow) |=> unplanned_intrusion && fault_flag;
   endproperty
   a_unpl_set: assert property (p_unpl_set) else $error("unplanned intrusion missed");
   property p_unpl_clear;
      $fell(unplanned_intrusion) |-> $past(quick_ok) || ($past(rearm_valid) && $past(presence_sensor_in));
   endproperty
   a_unpl_clear: assert property (p_unpl_clear) else $error("unplanned cleared without rearm");
   property p_tmo_clear;
      $fell(intrusion_timeout) |-> $past(rearm_valid);
   endproperty
   a_tmo_clear: assert property (p_tmo_clear) else $error("timeout cleared without rearm");
   property p_fault;
      (unplanned_intrusion || intrusion_timeout) |-> !motion_permit && fault_flag;
   endproperty
   a_fault: assert property (p_fault) else $error("error without fault or with permit");

   property p_tmo_off;
      (tmo_limit == 16'h0000) |=> !$rose(intrusion_timeout);
   endproperty
   a_tmo_off: assert property (p_tmo_off) else $error("timeout while disabled");

   property p_tdc_count;
      tdc_rise |=> intr_cnt == 2'h0;
   endproperty
   a_tdc_count: assert property (p_tdc_count) else $error("count not cleared at top");

   c_permit: cover property (@(posedge clk) $rose(motion_permit));
   c_unpl: cover property (@(posedge clk) $rose(unplanned_intrusion));
   c_tmo: cover property (@(posedge clk) $rose(intrusion_timeout));
   c_cycle: cover property (@(posedge clk) state == PIC_ST_RUN && tdc_rise);
endmodule // pic_press_intrusion_cycle_ctrl

// ==== test/pic_press_model.sv ====
`timescale 1ns/1ps
module pic_press_model #(
   parameter int STEP = 200
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic motion_permit,
   output logic top_dead_centre_position,
   output logic rising_stroke,
   output logic drive_active_fb
);
   // Crank position in cycles, advances only while driven
   int pos;
   assign drive_active_fb = motion_permit;
   assign top_dead_centre_position = pos < 20;
   assign rising_stroke = pos >= 2 * STEP;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pos <= 0;
      end else if (drive_active_fb) begin
         pos <= (pos == 3 * STEP - 1) ? 0 : pos + 1;
      end
   end
endmodule // pic_press_model

// ==== test/press_intrusion_cycle_ctrl_test.sv ====
`timescale 1ns/1ps
module press_intrusion_cycle_ctrl_test import pic_pkg::*;;
   logic clk = 0, sys_rst = 1, static_permit = 0, start_permit = 0, presence_sensor_in = 1, rearm_in = 0;
   logic reg_wr = 0, reg_rd = 0;
   logic [PIC_AW-1:0] reg_addr = '0;
   logic [PIC_DW-1:0] reg_wdata = '0;
   logic [PIC_DW-1:0] reg_rdata;
   logic top_dead_centre_position, rising_stroke, drive_active_fb;
   logic motion_permit, rearm_needed, intrusion_expected, unplanned_intrusion, intrusion_timeout, fault_flag;
   logic [6:0] outs;
   logic [15:0] rv [4];
   int num_errors = 0, samples_checked = 0, cycles = 0;
   logic [31:0] seed = 32'd44178;
   assign outs = {rising_stroke, fault_flag, intrusion_timeout, unplanned_intrusion, intrusion_expected,
      rearm_needed, motion_permit};

   pic_press_intrusion_cycle_ctrl #(.TICK_CYCLES(10)) DUT (.clk, .sys_rst, .static_permit, .start_permit,
      .presence_sensor_in, .top_dead_centre_position, .rising_stroke, .rearm_in, .drive_active_fb, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .motion_permit, .rearm_needed, .intrusion_expected,
      .unplanned_intrusion, .intrusion_timeout, .fault_flag);
   pic_press_model #(.STEP(200)) partner (.clk, .sys_rst, .motion_permit, .top_dead_centre_position,
      .rising_stroke, .drive_active_fb);

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic stop_test();
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         num_errors++;
         stop_test();
      end
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic int rms();
      return 120 + int'(rnd() % 60);
   endfunction

   task automatic chk(string n, logic [15:0] s, logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(logic [PIC_AW-1:0] a, logic [PIC_DW-1:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge clk);
      reg_wr <= 0;
   endtask

   task automatic rdchk(string n, logic [PIC_AW-1:0] a, logic [PIC_DW-1:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge clk);
      reg_rd <= 0;
      #1 chk(n, reg_rdata, e);
      cyc(1);
      chk("rdata idle", reg_rdata, 16'h0);
   endtask

   task automatic intr(int ms);
      @(posedge clk) presence_sensor_in <= 0;
      repeat (ms * 10) @(posedge clk);
      presence_sensor_in <= 1;
   endtask

   task automatic rearm(int ms);
      @(posedge clk) rearm_in <= 1;
      repeat (ms * 10) @(posedge clk);
      rearm_in <= 0;
   endtask

   task automatic waitchk(string n, int i, logic v, int lim);
      int k;
      k = 0;
      while (outs[i] !== v && k < lim) begin
         cyc(1);
         k++;
      end
      chk(n, 16'(outs[i]), 16'(v));
   endtask

   initial begin
      rv = '{PIC_CTRL_RST, PIC_MUTE_RST, PIC_TMO_RST, 16'h0};
      repeat (4) @(posedge clk);
      sys_rst <= 0;
      cyc(1);
      chk("outputs", 16'(outs[5:0]), 16'h0);
      for (int a = 0; a < 4; a++) begin
         rdchk("reg reset", 2'(a), rv[a]);
      end
      // Policy none with start permit used
      wr(PIC_ADDR_CTRL, 16'h0064);
      @(posedge clk) static_permit <= 1;
      waitchk("expected", 2, 1, 5);
      intr(rms());
      cyc(5);
      chk("permit no start", 16'(motion_permit), 16'h0);
      @(posedge clk) start_permit <= 1;
      waitchk("permit", 0, 1, 5);
      @(posedge clk) start_permit <= 0;
      cyc(3);
      chk("permit kept", 16'(motion_permit), 16'h1);
      @(posedge clk) presence_sensor_in <= 0;
      cyc(1);
      chk("permit drop", 16'(motion_permit), 16'h0);
      chk("unplanned", 16'(unplanned_intrusion), 16'h1);
      chk("fault", 16'(fault_flag), 16'h1);
      @(posedge clk) presence_sensor_in <= 1;
      start_permit <= 1;
      waitchk("unplanned clr", 3, 0, 5);
      chk("quick restart", 16'(intrusion_expected), 16'h1);
      intr(rms());
      waitchk("permit", 0, 1, 5);
      waitchk("cycle start", 2, 1, 700);
      chk("permit at top", 16'(motion_permit), 16'h0);
      rdchk("status", PIC_ADDR_STAT, 16'h0002);
      intr(rms());
      waitchk("permit", 0, 1, 5);
      @(posedge clk) static_permit <= 0;
      cyc(1);
      chk("static off", 16'(motion_permit), 16'h0);
      // Policy all stops from reset values
      @(posedge clk) sys_rst <= 1;
      static_permit <= 1;
      cyc(2);
      chk("outputs rst", 16'(outs[5:0]), 16'h0);
      @(posedge clk) sys_rst <= 0;
      waitchk("rearm needed", 1, 1, 5);
      rearm(50);
      cyc(20);
      chk("short rearm", 16'(rearm_needed), 16'h1);
      rearm(rms());
      waitchk("expected", 2, 1, 5);
      chk("rearm done", 16'(rearm_needed), 16'h0);
      intr(rms());
      waitchk("permit", 0, 1, 5);
      waitchk("upstroke", 6, 1, 700);
      @(posedge clk) presence_sensor_in <= 0;
      cyc(1);
      chk("upstroke drop", 16'(motion_permit), 16'h0);
      chk("unplanned", 16'(unplanned_intrusion), 16'h1);
      rearm(rms());
      cyc(3);
      chk("rearm sensor low", 16'(unplanned_intrusion), 16'h1);
      @(posedge clk) presence_sensor_in <= 1;
      cyc(3);
      chk("sensor only", 16'(unplanned_intrusion), 16'h1);
      rearm(rms());
      waitchk("unplanned clr", 3, 0, 5);
      chk("fault clr", 16'(fault_flag), 16'h0);
      wr(PIC_ADDR_TMO, 16'h0032);
      cyc(400);
      chk("timeout early", 16'(intrusion_timeout), 16'h0);
      waitchk("timeout", 4, 1, 200);
      chk("timeout fault", 16'(fault_flag), 16'h1);
      chk("timeout permit", 16'(motion_permit), 16'h0);
      cyc(300);
      chk("timeout sticky", 16'(intrusion_timeout), 16'h1);
      rearm(rms());
      waitchk("timeout clr", 4, 0, 5);
      wr(PIC_ADDR_TMO, 16'h0000);
      cyc(1000);
      chk("timeout off", 16'(intrusion_timeout), 16'h0);
      // Muting under policy all stops
      wr(PIC_ADDR_MUTE, 16'h000a);
      intr(rms());
      waitchk("permit mute", 0, 1, 5);
      waitchk("full restart", 1, 1, 300);
      chk("permit at top", 16'(motion_permit), 16'h0);
      rearm(rms());
      waitchk("expected", 2, 1, 5);
      intr(rms());
      waitchk("permit", 0, 1, 5);
      waitchk("upstroke", 6, 1, 700);
      @(posedge clk) presence_sensor_in <= 0;
      cyc(5);
      chk("muted", 16'(motion_permit), 16'h1);
      chk("muted no error", 16'(unplanned_intrusion), 16'h0);
      waitchk("mute expiry", 0, 0, 150);
      chk("follow no error", 16'(fault_flag), 16'h0);
      @(posedge clk) presence_sensor_in <= 1;
      waitchk("follow back", 0, 1, 5);
      waitchk("rearm at top", 1, 1, 300);
      // Downstroke policy, long minimum, two interventions
      wr(PIC_ADDR_CTRL, 16'h00ba);
      rearm(rms());
      cyc(3);
      chk("short for long min", 16'(rearm_needed), 16'h1);
      rearm(400);
      waitchk("expected", 2, 1, 5);
      intr(rms());
      cyc(3);
      chk("short intervention", 16'(motion_permit), 16'h0);
      intr(400);
      cyc(3);
      chk("one of two", 16'(motion_permit), 16'h0);
      intr(400);
      waitchk("permit two", 0, 1, 5);
      waitchk("upstroke", 6, 1, 700);
      @(posedge clk) presence_sensor_in <= 0;
      cyc(150);
      chk("down hold", 16'(motion_permit), 16'h1);
      chk("down no error", 16'(unplanned_intrusion), 16'h0);
      @(posedge clk) presence_sensor_in <= 1;
      waitchk("cycle start down", 2, 1, 300);
      chk("permit stop down", 16'(motion_permit), 16'h0);
      stop_test();
   end
endmodule // press_intrusion_cycle_ctrl_test
